// ===== dsb_map.vh
`ifndef DSB_MAP_VH
`define DSB_MAP_VH

// ----------------------------------------
// Organisation
// ----------------------------------------
`define DSB_DATA_W 18
`define DSB_ADDR_W 20
`define DSB_LANES 2
`define DSB_LANE0_LSB 0
`define DSB_LANE0_MSB 8
`define DSB_LANE1_LSB 9
`define DSB_LANE1_MSB 17
`define DSB_UNBONDED 4

// ----------------------------------------
// Buffering
// ----------------------------------------
`define DSB_FIFO_DEPTH 16
`define DSB_FIFO_PTR_W 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DSB_RST_DATA 18'h00000
`define DSB_RST_ADDR 20'h00000
`define DSB_RST_MASK 2'h3

`endif

// ===== dsb_port.v
// Summary of operation
// - Write: strobe low, direction low at K; words taken at next K then /K.
// - Read: strobe low, direction high at K; words on /C of next cycle, then C.
// - Write words registered on rising K and rising /K, two per period.
// - Output clocks both held high: read data timed to K and /K instead.
// - Control inputs sampled only on rising K.
// - Read bus stays high impedance from power-up until a read.
// - Delay-loop bypass input low bypasses the internal delay loop.
// - Each unbonded ball level is captured as a scan chain bit.
// - Low mask writes its lane; masks given separately per data edge.
// - Echo clocks run freely, aligned with read data, even when bus floats.
`timescale 1ns/1ps
`default_nettype none
`include "dsb_map.vh"

module dsb_fifo
#(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter PTR_W = 4
)
(
	input wire clk,
	input wire rst_b,
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [PTR_W-1:0] wrPtr;
	reg [PTR_W-1:0] rdPtr;
	reg [PTR_W:0] count;
	wire doPush;
	wire doPop;

	assign inReady = (count != DEPTH);
	assign outValid = (count != 0);
	assign outData = store[rdPtr];
	assign doPush = inValid && inReady;
	assign doPop = outValid && outReady;

	always @(posedge clk)
	begin
		if (doPush)
			store[wrPtr] <= inData;
	end

	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wrPtr <= {PTR_W{1'b0}};
			rdPtr <= {PTR_W{1'b0}};
			count <= {(PTR_W+1){1'b0}};
		end
		else
		begin
			if (doPush)
				wrPtr <= wrPtr + 1'b1;
			if (doPop)
				rdPtr <= rdPtr + 1'b1;
			if (doPush && !doPop)
				count <= count + 1'b1;
			else if (doPop && !doPush)
				count <= count - 1'b1;
		end
	end
endmodule

module dsb_port
(
	input wire clk,
	input wire rst_b,
	input wire kIn,
	input wire kInN,
	input wire cIn,
	input wire cInN,
	input wire transfer_strobe_n,
	input wire readNotWrite,
	input wire [`DSB_ADDR_W-1:0] address,
	input wire [`DSB_DATA_W-1:0] write_bus_in,
	input wire [`DSB_LANES-1:0] byte_lane_mask_n,
	input wire delayLoopBypassN,
	input wire [`DSB_UNBONDED-1:0] unbondedBall,
	output reg [`DSB_DATA_W-1:0] fetch_bus_out,
	output reg fetchBusOe,
	output reg mirror_strobe_out,
	output reg mirrorStrobeOutN,
	output reg [`DSB_UNBONDED-1:0] scanChainLevel,
	output wire writeBufferReady
);
	localparam ENTRY_W = `DSB_ADDR_W + 1 + `DSB_DATA_W + `DSB_LANES;
	localparam SYNC_W = 7 + `DSB_ADDR_W + `DSB_DATA_W + `DSB_LANES + `DSB_UNBONDED;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	wire [SYNC_W-1:0] pinRaw;
	reg [SYNC_W-1:0] pinMeta;
	reg [SYNC_W-1:0] pinSync;
	reg [3:0] clkPrev;
	assign pinRaw = {kIn, kInN, cIn, cInN, transfer_strobe_n, readNotWrite, address,
		write_bus_in, byte_lane_mask_n, delayLoopBypassN, unbondedBall};
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pinMeta <= {SYNC_W{1'b0}};
			pinSync <= {SYNC_W{1'b0}};
			clkPrev <= 4'h0;
		end
		else
		begin
			pinMeta <= pinRaw;
			pinSync <= pinMeta;
			clkPrev <= pinSync[SYNC_W-1:SYNC_W-4];
		end
	end

	wire sK = pinSync[SYNC_W-1];
	wire sKN = pinSync[SYNC_W-2];
	wire sC = pinSync[SYNC_W-3];
	wire sCN = pinSync[SYNC_W-4];
	wire sStrobeN = pinSync[SYNC_W-5];
	wire sRead = pinSync[SYNC_W-6];
	wire [`DSB_ADDR_W-1:0] sAddr = pinSync[SYNC_W-7 -: `DSB_ADDR_W];
	wire [`DSB_DATA_W-1:0] sData = pinSync[`DSB_LANES+1+`DSB_UNBONDED +: `DSB_DATA_W];
	wire [`DSB_LANES-1:0] sMaskN = pinSync[1+`DSB_UNBONDED +: `DSB_LANES];
	wire sBypassN = pinSync[`DSB_UNBONDED];
	wire kRise = sK && !clkPrev[3];
	wire kNRise = sKN && !clkPrev[2];
	// Output clocks high select K pair
	wire useK = sC && sCN;
	wire refRise = useK ? kRise : (sC && !clkPrev[1]);
	wire refNRise = useK ? kNRise : (sCN && !clkPrev[0]);

	// ----------------------------------------
	// Lane merge
	// ----------------------------------------
	// Lane bit ranges
	function [`DSB_DATA_W-1:0] mergeLanes;
		input [`DSB_DATA_W-1:0] oldWord;
		input [`DSB_DATA_W-1:0] newWord;
		input [`DSB_LANES-1:0] maskN;
		begin
			mergeLanes = oldWord;
			if (!maskN[0])
				mergeLanes[`DSB_LANE0_MSB:`DSB_LANE0_LSB] = newWord[`DSB_LANE0_MSB:`DSB_LANE0_LSB];
			if (!maskN[1])
				mergeLanes[`DSB_LANE1_MSB:`DSB_LANE1_LSB] = newWord[`DSB_LANE1_MSB:`DSB_LANE1_LSB];
		end
	endfunction

	// ----------------------------------------
	// Write capture
	// ----------------------------------------
	reg writeArmed;
	reg writeSecond;
	reg [`DSB_ADDR_W-1:0] writeAddr;
	reg [ENTRY_W-1:0] pushEntry;
	reg pushValid;
	wire readCmd = kRise && !sStrobeN && sRead;
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			writeArmed <= 1'b0;
			writeSecond <= 1'b0;
			writeAddr <= `DSB_RST_ADDR;
			pushEntry <= {ENTRY_W{1'b0}};
			pushValid <= 1'b0;
		end
		else
		begin
			pushValid <= 1'b0;
			if (kRise)
			begin
				if (writeArmed)
				begin
					pushEntry <= {writeAddr, 1'b0, sData, sMaskN};
					pushValid <= 1'b1;
				end
				writeSecond <= writeArmed;
				writeArmed <= !sStrobeN && !sRead;
				if (!sStrobeN && !sRead)
					writeAddr <= sAddr;
			end
			else if (kNRise && writeSecond)
			begin
				pushEntry <= {pushEntry[ENTRY_W-1 -: `DSB_ADDR_W], 1'b1, sData, sMaskN};
				pushValid <= 1'b1;
				writeSecond <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Write buffer and array
	// ----------------------------------------
	reg [`DSB_DATA_W-1:0] cells [0:(1<<(`DSB_ADDR_W+1))-1];
	wire drainValid;
	wire [ENTRY_W-1:0] drainEntry;
	wire drainReady = !readCmd;
	dsb_fifo #(.WIDTH(ENTRY_W), .DEPTH(`DSB_FIFO_DEPTH), .PTR_W(`DSB_FIFO_PTR_W)) writeBuffer
	(
		.clk(clk),
		.rst_b(rst_b),
		.inValid(pushValid),
		.inReady(writeBufferReady),
		.inData(pushEntry),
		.outValid(drainValid),
		.outReady(drainReady),
		.outData(drainEntry)
	);
	wire [`DSB_ADDR_W:0] drainAddr = drainEntry[ENTRY_W-1 -: `DSB_ADDR_W+1];
	always @(posedge clk)
	begin
		if (drainValid && drainReady)
			cells[drainAddr] <= mergeLanes(cells[drainAddr], drainEntry[`DSB_LANES +: `DSB_DATA_W],
				drainEntry[`DSB_LANES-1:0]);
	end

	// ----------------------------------------
	// Read pipeline
	// ----------------------------------------
	reg pendValid;
	reg [`DSB_DATA_W-1:0] pendWord0;
	reg [`DSB_DATA_W-1:0] pendWord1;
	reg midValid;
	reg [`DSB_DATA_W-1:0] midWord0;
	reg [`DSB_DATA_W-1:0] midWord1;
	reg activeValid;
	reg [`DSB_DATA_W-1:0] activeWord1;
	reg [`DSB_DATA_W-1:0] next_bus;
	reg next_oe;
	reg [`DSB_DATA_W-1:0] stageBus;
	reg stageOe;
	reg [1:0] echoPipe;
	wire [1:0] refLevel = useK ? clkPrev[3:2] : clkPrev[1:0];
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pendValid <= 1'b0;
			pendWord0 <= `DSB_RST_DATA;
			pendWord1 <= `DSB_RST_DATA;
			midValid <= 1'b0;
			midWord0 <= `DSB_RST_DATA;
			midWord1 <= `DSB_RST_DATA;
			activeValid <= 1'b0;
			activeWord1 <= `DSB_RST_DATA;
			next_bus <= `DSB_RST_DATA;
			next_oe <= 1'b0;
		end
		else
		begin
			if (readCmd)
			begin
				pendValid <= 1'b1;
				pendWord0 <= cells[{sAddr, 1'b0}];
				pendWord1 <= cells[{sAddr, 1'b1}];
			end
			if (refNRise)
			begin
				// First /C after command only advances
				midValid <= pendValid;
				midWord0 <= pendWord0;
				midWord1 <= pendWord1;
				next_oe <= midValid;
				next_bus <= midValid ? midWord0 : next_bus;
				activeValid <= midValid;
				activeWord1 <= midWord1;
				if (!readCmd)
					pendValid <= 1'b0;
			end
			else if (refRise && activeValid)
			begin
				next_bus <= activeWord1;
				next_oe <= 1'b1;
				activeValid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Output launch and echo clocks
	// ----------------------------------------
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fetch_bus_out <= `DSB_RST_DATA;
			fetchBusOe <= 1'b0;
			stageBus <= `DSB_RST_DATA;
			stageOe <= 1'b0;
			mirror_strobe_out <= 1'b0;
			mirrorStrobeOutN <= 1'b0;
			scanChainLevel <= {`DSB_UNBONDED{1'b0}};
			echoPipe <= 2'h0;
		end
		else
		begin
			stageBus <= next_bus;
			stageOe <= next_oe;
			if (!sBypassN)
			begin
				fetch_bus_out <= next_bus;
				fetchBusOe <= next_oe;
				mirror_strobe_out <= refLevel[1];
				mirrorStrobeOutN <= refLevel[0];
			end
			else
			begin
				fetch_bus_out <= stageBus;
				fetchBusOe <= stageOe;
				mirror_strobe_out <= echoPipe[1];
				mirrorStrobeOutN <= echoPipe[0];
			end
			// Echo delayed like the data stage
			echoPipe <= refLevel;
			scanChainLevel <= pinSync[`DSB_UNBONDED-1:0];
		end
	end
endmodule
`default_nettype wire

// ===== dsb_port_tail_unused.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== dsb_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsb_map.vh"
module dsb_port_asserts(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic kIn,
	input wire logic kInN,
	input wire logic cIn,
	input wire logic cInN,
	input wire logic transfer_strobe_n,
	input wire logic readNotWrite,
	input wire logic [`DSB_UNBONDED-1:0] unbondedBall,
	input wire logic fetchBusOe,
	input wire logic mirror_strobe_out,
	input wire logic mirrorStrobeOutN,
	input wire logic [`DSB_UNBONDED-1:0] scanChainLevel,
	input wire logic writeBufferReady
);
	// ----------------------------------------
	// Cycles since reset and since last strobe
	// ----------------------------------------
	logic [7:0] cyc;
	logic [7:0] idle;
	logic readSeen;
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			cyc <= 8'h00;
			idle <= 8'h00;
			readSeen <= 1'b0;
		end
		else
		begin
			cyc <= cyc + {7'h00, cyc != 8'hFF};
			idle <= transfer_strobe_n ? idle + {7'h00, idle != 8'hFF} : 8'h00;
			readSeen <= readSeen | (!transfer_strobe_n & readNotWrite);
		end
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_scan_level: assert property ((cyc > 8 && $stable(unbondedBall))[*5] |-> scanChainLevel == unbondedBall)
		else $error("scan level wrong");
	a_float_power: assert property ($rose(fetchBusOe) |-> readSeen)
		else $error("read bus driven before a read");
	a_echo_kref: assert property ((cIn && cInN && $stable(kIn) && cyc > 8)[*6] |-> mirror_strobe_out == kIn)
		else $error("echo not on input clock");
	a_echo_cref: assert property ((cIn != cInN && $stable(cIn) && cyc > 8)[*6] |-> mirrorStrobeOutN == cInN)
		else $error("echo not on output clock");
	a_nop_release: assert property (idle > 160 |-> !fetchBusOe)
		else $error("read bus driven while idle");
	a_read_answer: assert property ($fell(transfer_strobe_n) && readNotWrite |-> ##[1:200] fetchBusOe)
		else $error("read not answered");
	a_write_quiet: assert property ($fell(transfer_strobe_n) && !readNotWrite && idle > 160 |=> !fetchBusOe[*8])
		else $error("write drove read bus");
	a_ready_idle: assert property (idle > 200 |-> writeBufferReady)
		else $error("write buffer not drained");
	cover property ($rose(fetchBusOe));
	cover property (!kIn && !kInN && !cIn && !cInN);
	cover property (cIn && cInN && $rose(fetchBusOe));
	cover property ($fell(transfer_strobe_n) && !readNotWrite);
endmodule
bind dsb_port dsb_port_asserts u_dsb_port_asserts(.*);
`default_nettype wire

// ===== dsb_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsb_ctrl_model(
	input wire logic clk,
	input wire logic cHigh,
	output logic kIn,
	output logic kInN,
	output wire logic cIn,
	output wire logic cInN,
	output logic transfer_strobe_n,
	output logic readNotWrite,
	output logic [19:0] address,
	output logic [17:0] write_bus_in,
	output logic [1:0] byte_lane_mask_n
);
	logic parked;
	// Output pair copies K or is held high
	assign cIn = cHigh | kIn;
	assign cInN = cHigh | kInN;
	initial
	begin
		parked = 1'b0;
		kIn = 1'b0;
		kInN = 1'b1;
		transfer_strobe_n = 1'b1;
		readNotWrite = 1'b0;
		address = 20'h00000;
		write_bus_in = 18'h00000;
		byte_lane_mask_n = 2'h3;
		#1.3;
		forever
		begin
			#80;
			if (parked)
			begin
				kIn = 1'b0;
				kInN = 1'b0;
			end
			else
			begin
				kIn = ~kIn;
				kInN = ~kIn;
			end
		end
	end
	// Stop or restart on a clock tick
	task automatic park(input logic on);
		@(posedge clk);
		#1;
		parked = on;
	endtask
	task automatic settle(input logic onKn);
		if (onKn)
			@(posedge kInN);
		else
			@(posedge kIn);
		repeat (10) @(posedge clk);
		#1;
	endtask
	// Command, then one word per edge
	task automatic doWrite(input logic [19:0] a, input logic [17:0] d0, input logic [17:0] d1,
		input logic [1:0] m0, input logic [1:0] m1);
		settle(1'b1);
		transfer_strobe_n = 1'b0;
		readNotWrite = 1'b0;
		address = a;
		settle(1'b0);
		transfer_strobe_n = 1'b1;
		readNotWrite = 1'b1;
		address = ~a;
		write_bus_in = d0;
		byte_lane_mask_n = m0;
		settle(1'b0);
		write_bus_in = d1;
		byte_lane_mask_n = m1;
		settle(1'b1);
		write_bus_in = ~d1;
		byte_lane_mask_n = 2'h3;
	endtask
	task automatic doRead(input logic [19:0] a);
		settle(1'b1);
		transfer_strobe_n = 1'b0;
		readNotWrite = 1'b1;
		address = a;
		settle(1'b0);
		transfer_strobe_n = 1'b1;
		readNotWrite = 1'b0;
		address = ~a;
	endtask
endmodule
`default_nettype wire

// ===== dsb_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsb_map.vh"
module dsb_port_bench;
	logic clk;
	logic rst_b;
	logic cHigh;
	logic dllN;
	logic [3:0] ball;
	wire kIn, kInN, cIn, cInN, strobeN, rnw, oe, echo, echoN, ready;
	wire [19:0] addr;
	wire [17:0] wData;
	wire [17:0] rData;
	wire [1:0] maskN;
	wire [3:0] scan;
	int nErrors;
	int checksDone;
	dsb_port u_dsb_port(.clk(clk), .rst_b(rst_b), .kIn(kIn), .kInN(kInN), .cIn(cIn), .cInN(cInN),
		.transfer_strobe_n(strobeN), .readNotWrite(rnw), .address(addr), .write_bus_in(wData),
		.byte_lane_mask_n(maskN), .delayLoopBypassN(dllN), .unbondedBall(ball), .fetch_bus_out(rData),
		.fetchBusOe(oe), .mirror_strobe_out(echo), .mirrorStrobeOutN(echoN), .scanChainLevel(scan),
		.writeBufferReady(ready));
	dsb_ctrl_model u_dsb_ctrl_model(.clk(clk), .cHigh(cHigh), .kIn(kIn), .kInN(kInN), .cIn(cIn), .cInN(cInN),
		.transfer_strobe_n(strobeN), .readNotWrite(rnw), .address(addr), .write_bus_in(wData),
		.byte_lane_mask_n(maskN));
	task automatic endSim;
		if (nErrors == 0 && checksDone > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chkWord(input logic [17:0] got, input logic [17:0] exp);
		checksDone++;
		if (got !== exp)
		begin
			nErrors++;
			$display("Error %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chkFlag(input logic got, input logic exp);
		chkWord({17'h00000, got}, {17'h00000, exp});
	endtask
	task automatic waitOe(input logic lvl);
		for (int i = 0; i < 300 && oe !== lvl; i++)
			@(negedge clk);
		chkFlag(oe, lvl);
		if (oe !== lvl)
			endSim;
	endtask
	task automatic readPair(input logic [17:0] e0, input logic [17:0] e1);
		fork
			u_dsb_ctrl_model.doRead(20'h00012);
		join_none
		waitOe(1'b1);
		chkWord(rData, e0);
		repeat (30) @(negedge clk);
		chkWord(rData, e1);
		chkFlag(oe, 1'b1);
		waitOe(1'b0);
	endtask
	task automatic tReset;
		chkFlag(oe, 1'b0);
		chkFlag(ready, 1'b1);
		chkWord({14'h0000, scan}, 18'h0000A);
		@(posedge clk);
		#1;
		ball = 4'h5;
		repeat (6) @(negedge clk);
		chkWord({14'h0000, scan}, 18'h00005);
	endtask
	task automatic tWriteRead;
		u_dsb_ctrl_model.doWrite(20'h00012, 18'h2A5C3, 18'h15A3C, 2'h0, 2'h0);
		readPair(18'h2A5C3, 18'h15A3C);
	endtask
	task automatic tMask;
		u_dsb_ctrl_model.doWrite(20'h00012, 18'h3FFFF, 18'h00000, 2'h2, 2'h1);
		readPair(18'h2A5FF, 18'h0003C);
	endtask
	task automatic tStop;
		u_dsb_ctrl_model.park(1'b1);
		repeat (200) @(negedge clk);
		chkFlag(oe, 1'b0);
		chkWord(rData, 18'h0003C);
		u_dsb_ctrl_model.park(1'b0);
	endtask
	task automatic tRefK;
		@(posedge clk);
		#1;
		cHigh = 1'b1;
		dllN = 1'b0;
		readPair(18'h2A5FF, 18'h0003C);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		rst_b = 1'b0;
		cHigh = 1'b0;
		dllN = 1'b1;
		ball = 4'hA;
		nErrors = 0;
		checksDone = 0;
		repeat (5) @(posedge clk);
		#1;
		rst_b = 1'b1;
		repeat (250) @(posedge clk);
		tReset;
		tWriteRead;
		tMask;
		tStop;
		tRefK;
		endSim;
	end
	// Run limit
	initial
	begin
		repeat (60000) @(posedge clk);
		nErrors++;
		$display("Error %0t: run limit reached", $time);
		endSim;
	end
endmodule
`default_nettype wire
